/* File: design/printer_port_pkg.sv */
// Purpose: shared constants and types for the printer port block
// Assumes: 8-bit register port, 25 MHz clock
// Notes: offsets are register indices on the plain register port
package printer_port_pkg;

	localparam int ADDR_W = 2;
	localparam int DATA_W = 8;
	localparam int CLOCK_MHZ = 25;
	localparam int SYNC_STAGES = 2;

	// register offsets
	localparam logic [ADDR_W-1:0] OFF_DATA = 2'h0;
	localparam logic [ADDR_W-1:0] OFF_STATUS = 2'h1;
	localparam logic [ADDR_W-1:0] OFF_CONTROL = 2'h2;
	localparam logic [ADDR_W-1:0] OFF_UNUSED = 2'h3;

	// control register fields
	localparam int CTL_STROBE = 0;
	localparam int CTL_LINEFEED = 1;
	localparam int CTL_INIT = 2;
	localparam int CTL_SELECT = 3;
	localparam int CTL_DIR_IN = 5;
	localparam int CTL_ENABLE = 7;
	localparam logic [7:0] CTL_WRITABLE = 8'hAF;

	// status register fields
	localparam int STA_REFUSED = 0;
	localparam int STA_ACK_SEEN = 2;
	localparam int STA_FAULT = 3;
	localparam int STA_SELECTED = 4;
	localparam int STA_NO_MEDIA = 5;
	localparam int STA_ACK = 6;
	localparam int STA_NOT_BUSY = 7;

	// reset values
	localparam logic [7:0] CONTROL_RST = 8'h04;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic [7:0] RDATA_IDLE = 8'h00;
	localparam logic [7:0] UNMAPPED_VALUE = 8'h00;

	typedef struct packed {
		logic printer_selected;
		logic no_media_flag;
		logic busy;
		logic char_accepted_n;
		logic fault_n;
	} printer_status_s;

	// idle cable: acknowledge and fault lines high
	localparam printer_status_s STATUS_IDLE = 5'h03;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} reg_req_s;

endpackage

/* File: design/level_sync.sv */
// Purpose: two-stage synchroniser for a group of pin levels
// Assumes: inputs are asynchronous levels, not pulses
// Notes: first stage is read only by the second stage
`timescale 1ns/1ps
module level_sync #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] stable_reg;

	always_ff @(posedge clock) begin
		if (reset) begin
			meta_reg <= RESET_VALUE;
			stable_reg <= RESET_VALUE;
		end else begin
			meta_reg <= async_in;
			stable_reg <= meta_reg;
		end
	end

	assign sync_out = stable_reg;

endmodule

/* File: design/printer_port.sv */
// Purpose: byte-wide printer port, register side and cable side
// Assumes: printer keeps its own handshake; pins asynchronous
// Notes: registers are data, status and control on a plain port
// Functional notes
// - select output is inverse of control bit 3
// - fault low readable in status bit 3
// - auto linefeed output inverse of control bit 1
// - strobe output is inverse of control bit 0
// - byte bus bidirectional, floats when deselected
`timescale 1ns/1ps
module printer_port
	import printer_port_pkg::*;
(
	input wire logic clock,
	input wire logic reset,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [DATA_W-1:0] reg_rdata,
	input wire logic printer_selected,
	input wire logic no_media_flag,
	input wire logic busy,
	input wire logic char_accepted_n,
	input wire logic fault_n,
	output logic select_printer_n,
	output logic auto_linefeed_n,
	output logic data_strobe_n,
	output logic init_n,
	input wire logic [DATA_W-1:0] port_byte_in,
	output logic [DATA_W-1:0] port_byte_out,
	output logic port_byte_oe
);

	reg_req_s req;
	printer_status_s status_pins;
	printer_status_s status_q;
	logic [DATA_W-1:0] byte_in_q;
	logic [7:0] control_reg;
	logic [DATA_W-1:0] data_reg;
	logic [DATA_W-1:0] rdata_reg;
	logic [DATA_W-1:0] rdata_next;
	logic refused_reg;
	logic ack_seen_reg;
	logic ack_prev_reg;
	logic ack_fall;
	logic data_wr;
	logic status_rd;
	logic control_wr;

	function automatic logic hit(input reg_req_s r, input logic [ADDR_W-1:0] off);
		hit = r.addr == off;
	endfunction

	assign req = '{wr: reg_wr, rd: reg_rd, addr: reg_addr, wdata: reg_wdata};
	assign data_wr = req.wr && hit(req, OFF_DATA);
	assign control_wr = req.wr && hit(req, OFF_CONTROL);
	assign status_rd = req.rd && hit(req, OFF_STATUS);

	assign status_pins = '{printer_selected: printer_selected,
		no_media_flag: no_media_flag,
		busy: busy,
		char_accepted_n: char_accepted_n,
		fault_n: fault_n};

	level_sync #(
		.WIDTH($bits(printer_status_s)),
		.RESET_VALUE(STATUS_IDLE)
	) u_status_sync (
		.clock(clock),
		.reset(reset),
		.async_in(status_pins),
		.sync_out(status_q)
	);

	// input byte is only trusted after two stages
	level_sync #(
		.WIDTH(DATA_W),
		.RESET_VALUE(DATA_RST)
	) u_byte_sync (
		.clock(clock),
		.reset(reset),
		.async_in(port_byte_in),
		.sync_out(byte_in_q)
	);

	always_ff @(posedge clock) begin
		if (reset) begin
			control_reg <= CONTROL_RST;
		end else if (control_wr) begin
			control_reg <= req.wdata & CTL_WRITABLE;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			data_reg <= DATA_RST;
		end else if (data_wr && !status_q.busy) begin
			data_reg <= req.wdata;
		end
	end

	// refused write is sticky; a new refusal wins over the read clear
	always_ff @(posedge clock) begin
		if (reset) begin
			refused_reg <= 1'b0;
		end else if (data_wr && status_q.busy) begin
			refused_reg <= 1'b1;
		end else if (status_rd) begin
			refused_reg <= 1'b0;
		end
	end

	// edge taken on synchronised level, never on the raw pin
	always_ff @(posedge clock) begin
		if (reset) begin
			ack_prev_reg <= 1'b1;
		end else begin
			ack_prev_reg <= status_q.char_accepted_n;
		end
	end

	assign ack_fall = ack_prev_reg && !status_q.char_accepted_n;

	always_ff @(posedge clock) begin
		if (reset) begin
			ack_seen_reg <= 1'b0;
		end else if (ack_fall) begin
			ack_seen_reg <= 1'b1;
		end else if (status_rd) begin
			ack_seen_reg <= 1'b0;
		end
	end

	always_comb begin
		rdata_next = RDATA_IDLE;
		if (req.rd) begin
			case (req.addr)
				OFF_DATA: begin
					rdata_next = control_reg[CTL_DIR_IN] ? byte_in_q : data_reg;
				end
				OFF_STATUS: begin
					rdata_next[STA_REFUSED] = refused_reg;
					rdata_next[STA_ACK_SEEN] = ack_seen_reg;
					rdata_next[STA_FAULT] = status_q.fault_n;
					rdata_next[STA_SELECTED] = status_q.printer_selected;
					rdata_next[STA_NO_MEDIA] = status_q.no_media_flag;
					rdata_next[STA_ACK] = status_q.char_accepted_n;
					rdata_next[STA_NOT_BUSY] = !status_q.busy;
				end
				OFF_CONTROL: begin
					rdata_next = control_reg;
				end
				default: begin
					rdata_next = UNMAPPED_VALUE;
				end
			endcase
		end
	end

	// read data stands for one cycle only
	always_ff @(posedge clock) begin
		if (reset) begin
			rdata_reg <= RDATA_IDLE;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	assign reg_rdata = rdata_reg;

	assign select_printer_n = !control_reg[CTL_SELECT];
	assign auto_linefeed_n = !control_reg[CTL_LINEFEED];
	assign data_strobe_n = !control_reg[CTL_STROBE];
	// init line is active low with no inversion, so reset leaves it high
	assign init_n = control_reg[CTL_INIT];

	assign port_byte_out = data_reg;
	assign port_byte_oe = control_reg[CTL_ENABLE] && !control_reg[CTL_DIR_IN];

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);

	a_select_follows_write: assert property (
		control_wr |=> select_printer_n == !$past(reg_wdata[CTL_SELECT])
	) else $error("select output does not follow control bit");

	a_linefeed_follows_write: assert property (
		control_wr |=> auto_linefeed_n == !$past(reg_wdata[CTL_LINEFEED])
	) else $error("linefeed output does not follow control bit");

	a_strobe_follows_write: assert property (
		control_wr |=> data_strobe_n == !$past(reg_wdata[CTL_STROBE])
	) else $error("strobe output does not follow control bit");

	a_strobe_holds_idle: assert property (
		!control_wr && !$past(control_wr) |-> $stable(data_strobe_n)
	) else $error("strobe output moved without a control write");

	a_fault_readable: assert property (
		status_rd |=> reg_rdata[STA_FAULT] == $past(fault_n, 3)
	) else $error("status bit 3 does not show the fault line");

	a_status_sync_delay: assert property (
		status_rd |=> reg_rdata[STA_SELECTED] == $past(printer_selected, 3)
			&& reg_rdata[STA_NO_MEDIA] == $past(no_media_flag, 3)
	) else $error("status read not two stages behind the pins");

	a_busy_blocks_data: assert property (
		data_wr && status_q.busy |=> $stable(port_byte_out) && refused_reg
	) else $error("byte changed while the printer was busy");

	a_float_deselect: assert property (
		control_wr && !reg_wdata[CTL_ENABLE] |=> !port_byte_oe [*1] ##1 ($past(control_wr) || !port_byte_oe)
	) else $error("byte bus driven while deselected");

	a_drive_selected: assert property (
		control_wr && reg_wdata[CTL_ENABLE] && !reg_wdata[CTL_DIR_IN] |=> port_byte_oe
	) else $error("byte bus not driven when enabled for output");

	a_rdata_one_cycle: assert property (
		!reg_rd |=> reg_rdata == RDATA_IDLE
	) else $error("read data stands outside its cycle");

	a_init_follows_write: assert property (
		control_wr |=> init_n == $past(reg_wdata[CTL_INIT])
	) else $error("init output does not follow control bit");

	a_select_holds_idle: assert property (
		!control_wr && !$past(control_wr) |-> $stable(select_printer_n)
	) else $error("select output moved without a control write");

	a_linefeed_holds_idle: assert property (
		!control_wr && !$past(control_wr) |-> $stable(auto_linefeed_n)
	) else $error("linefeed output moved without a control write");

	a_oe_follows_write: assert property (
		control_wr |=> port_byte_oe == ($past(reg_wdata[CTL_ENABLE]) && !$past(reg_wdata[CTL_DIR_IN]))
	) else $error("byte bus enable does not follow control bits");

	a_byte_taken_idle: assert property (
		data_wr && !status_q.busy |=> port_byte_out == $past(reg_wdata)
	) else $error("byte not taken while the printer was idle");

	a_refused_sets: assert property (
		data_wr && status_q.busy |=> refused_reg
	) else $error("refused flag not set by a write while busy");

	a_refused_clears: assert property (
		status_rd && !data_wr |=> !refused_reg
	) else $error("refused flag not cleared by a status read");

	a_ack_seen_sets: assert property (
		ack_fall |=> ack_seen_reg
	) else $error("acknowledge flag not set by a falling edge");

	a_ack_seen_clears: assert property (
		status_rd && !ack_fall |=> !ack_seen_reg
	) else $error("acknowledge flag not cleared by a status read");

	a_busy_bit_read: assert property (
		status_rd |=> reg_rdata[STA_NOT_BUSY] == !$past(busy, 3)
	) else $error("status bit 7 does not show the busy line");

	a_ack_bit_read: assert property (
		status_rd |=> reg_rdata[STA_ACK] == $past(char_accepted_n, 3)
	) else $error("status bit 6 does not show the acknowledge line");

	a_control_read: assert property (
		reg_rd && hit(req, OFF_CONTROL) |=> reg_rdata == $past(control_reg)
	) else $error("control read does not return the register");

	a_data_read_out: assert property (
		reg_rd && hit(req, OFF_DATA) && !control_reg[CTL_DIR_IN] |=> reg_rdata == $past(data_reg)
	) else $error("data read does not return the output byte");

	a_data_read_in: assert property (
		reg_rd && hit(req, OFF_DATA) && control_reg[CTL_DIR_IN] |=> reg_rdata == $past(port_byte_in, 3)
	) else $error("data read not two stages behind the byte bus");

	a_unmapped_zero: assert property (
		reg_rd && hit(req, OFF_UNUSED) |=> reg_rdata == UNMAPPED_VALUE
	) else $error("unmapped read does not return the idle value");

	c_byte_written: cover property (data_wr && !status_q.busy ##1 port_byte_oe);
	c_write_refused: cover property (data_wr && status_q.busy);
	c_ack_seen: cover property (ack_fall ##[1:20] status_rd);
	c_input_read: cover property (req.rd && hit(req, OFF_DATA) && control_reg[CTL_DIR_IN]);
	c_refused_read: cover property (refused_reg && status_rd);

endmodule

/* File: tb/printer_model.sv */
// Purpose: behavioural line printer on the cable side
// Assumes: strobe sampled on the bench clock
// Notes: busy, then an acknowledge pulse, after each latched byte
`timescale 1ns/1ps
module printer_model #(
	parameter int BUSY_CYC = 10,
	parameter int ACK_CYC = 2
) (
	input wire logic clock,
	input wire logic select_printer_n,
	input wire logic data_strobe_n,
	input wire logic [7:0] port_byte_out,
	input wire logic port_byte_oe,
	input wire logic paper_out,
	input wire logic error_on,
	input wire logic drv_en,
	input wire logic [7:0] drv_val,
	output logic printer_selected,
	output logic no_media_flag,
	output logic busy,
	output logic char_accepted_n,
	output logic fault_n,
	output logic [7:0] port_byte_in,
	output logic [7:0] got_byte
);
	logic strobe_d = 1'b1;
	logic [7:0] last = 8'h00;
	int cnt = 0;
	assign printer_selected = !select_printer_n;
	assign no_media_flag = paper_out;
	assign fault_n = !error_on;
	assign busy = cnt > ACK_CYC;
	assign char_accepted_n = !(cnt != 0 && cnt <= ACK_CYC);
	// released bus must not keep its last value, so it toggles
	assign port_byte_in = port_byte_oe ? port_byte_out : (drv_en ? drv_val : ~last);
	always @(posedge clock) begin
		last <= port_byte_in;
		strobe_d <= data_strobe_n;
		if (strobe_d && !data_strobe_n && cnt == 0) begin
			got_byte <= port_byte_in;
			cnt <= BUSY_CYC;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
endmodule

/* File: tb/printer_port_tb.sv */
// Purpose: self-checking bench for the printer port
// Assumes: printer model on the cable side
// Notes: status values are worked out by hand from the bit layout
`timescale 1ns/1ps
module printer_port_tb;
	import printer_port_pkg::*;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] reg_addr = '0;
	logic [DATA_W-1:0] reg_wdata = '0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [DATA_W-1:0] reg_rdata, port_byte_in, port_byte_out, got_byte, rd_val;
	logic printer_selected, no_media_flag, busy, char_accepted_n, fault_n;
	logic select_printer_n, auto_linefeed_n, data_strobe_n, init_n, port_byte_oe;
	logic paper_out = 1'b0;
	logic error_on = 1'b0;
	logic drv_en = 1'b0;
	logic [7:0] drv_val = 8'h00;
	int err_total = 0;
	int n_compared = 0;
	always #20 clock = ~clock;
	printer_port dut_u (.clock, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.printer_selected, .no_media_flag, .busy, .char_accepted_n, .fault_n, .select_printer_n,
		.auto_linefeed_n, .data_strobe_n, .init_n, .port_byte_in, .port_byte_out, .port_byte_oe);
	printer_model partner_u (.clock, .select_printer_n, .data_strobe_n, .port_byte_out, .port_byte_oe,
		.paper_out, .error_on, .drv_en, .drv_val, .printer_selected, .no_media_flag, .busy,
		.char_accepted_n, .fault_n, .port_byte_in, .got_byte);
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic [7:0] pins();
		return {3'h0, init_n, port_byte_oe, select_printer_n, auto_linefeed_n, data_strobe_n};
	endfunction
	task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
		#1;
	endtask
	task automatic reg_read(input logic [1:0] a);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		rd_val = reg_rdata;
	endtask
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic test_reset();
		reg_read(OFF_CONTROL);
		check("control", rd_val, CONTROL_RST);
		check("pins", pins(), 8'h17);
		reg_read(OFF_STATUS);
		check("status", rd_val, 8'hC8);
		$display("test reset done");
	endtask
	task automatic test_pins();
		logic [7:0] vals [5];
		logic [7:0] v;
		vals = '{8'h01, 8'h02, 8'h08, 8'h80, 8'hFF};
		foreach (vals[i]) begin
			v = vals[i];
			reg_write(OFF_CONTROL, v);
			check("pins", pins(), {3'h0, v[2], v[7] & ~v[5], ~v[3], ~v[1], ~v[0]});
			reg_read(OFF_CONTROL);
			check("control", rd_val, v & CTL_WRITABLE);
		end
		reg_read(OFF_UNUSED);
		check("unmapped", rd_val, UNMAPPED_VALUE);
		reg_write(OFF_CONTROL, 8'h00);
		// strobes above left the printer busy; let it settle before sending
		repeat (16) @(posedge clock);
		reg_read(OFF_STATUS);
		check("status idle", rd_val, 8'hCC);
		$display("test pins done");
	endtask
	task automatic test_send();
		reg_write(OFF_DATA, 8'hA5);
		reg_write(OFF_CONTROL, 8'h89);
		reg_write(OFF_CONTROL, 8'h88);
		repeat (2) @(posedge clock);
		// lands while the printer is still busy
		reg_write(OFF_DATA, 8'h5A);
		reg_read(OFF_STATUS);
		check("status busy", rd_val, 8'h59);
		repeat (15) @(posedge clock);
		reg_read(OFF_STATUS);
		check("status acked", rd_val, 8'hDC);
		reg_read(OFF_DATA);
		check("data kept", rd_val, 8'hA5);
		check("printer byte", got_byte, 8'hA5);
		$display("test send done");
	endtask
	task automatic test_status();
		reg_write(OFF_CONTROL, 8'h00);
		@(posedge clock);
		paper_out <= 1'b1;
		error_on <= 1'b1;
		repeat (4) @(posedge clock);
		reg_read(OFF_STATUS);
		check("status fault", rd_val, 8'hE0);
		@(posedge clock);
		paper_out <= 1'b0;
		error_on <= 1'b0;
		$display("test status done");
	endtask
	task automatic test_input();
		reg_write(OFF_CONTROL, 8'hA0);
		@(posedge clock);
		drv_en <= 1'b1;
		drv_val <= 8'h3C;
		repeat (3) @(posedge clock);
		reg_read(OFF_DATA);
		check("input byte", rd_val, 8'h3C);
		check("bus released", {7'h0, port_byte_oe}, 8'h00);
		$display("test input done");
	endtask
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		test_reset();
		test_pins();
		test_send();
		test_status();
		test_input();
		finish_test();
	end
	initial begin
		#(40 * 2000);
		err_total++;
		$display("watchdog expired");
		finish_test();
	end
endmodule
